/* src/plc_consts.svh */
// Register offsets, reset values and timing counts of the line controller.
// Included by the package, the controller and the bench; definitions only.
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH
`define PLC_OFF_CLAIM 8'h00
`define PLC_OFF_RELEASE 8'h04
`define PLC_OFF_OWN_STAT 8'h08
`define PLC_OFF_OE_SET 8'h10
`define PLC_OFF_OE_CLR 8'h14
`define PLC_OFF_OE_STAT 8'h18
`define PLC_OFF_GF_SET 8'h20
`define PLC_OFF_GF_CLR 8'h24
`define PLC_OFF_GF_STAT 8'h28
`define PLC_OFF_OL_SET 8'h30
`define PLC_OFF_OL_CLR 8'h34
`define PLC_OFF_OL_STAT 8'h38
`define PLC_OFF_PIN_STAT 8'h3c
`define PLC_RST_OWN_A 32'h3fffffff
`define PLC_RST_OWN_B 32'h00ffffff
`define PLC_RST_ZERO 32'h00000000
`define PLC_GF_LEN 2
`define PLC_RESP_OKAY 2'b00
`define PLC_RESP_SLVERR 2'b10
`endif

/* src/plc_ctrl.sv */
// Parallel line controller: 32 lines, set/clear/status registers on AXI4-Lite.
// Assumes pins arrive asynchronously and peripherals sit on mclk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "plc_consts.svh"
// Operation
// - Writing one to line_release returns that line to its peripheral.
// - Ownership status updates on every claim or release, instance-chosen reset.
// - Ownership bit is one when controller owns line, zero for peripheral.
// - output_enable_set sets stored enable; no pin effect under peripheral.
// - output_enable_clear clears stored enable even under peripheral; zeros ignored.
// - Output status shows enables, resets zero, acts only under ownership.
// - glitch_filter_set selects the filter whatever the ownership.
// - glitch_filter_clear deselects the filter whatever the ownership.
// - Filter status resets zero; filter serves peripheral and controller paths.
// - With filter selected and clock stopped, filtered values hold.
// - output_latch_set sets latch; pin follows only if enabled and owned.
// - output_latch_clear clears latch; pin affected only if enabled and owned.
// - Latch status resets zero; reaches pin only if owned and output.
// - line_claim gives controller the pin; peripheral input held at zero.
// - Pin level status returns the synchronised pin level, filtered on lines with the filter selected.
module plc_ctrl #(
    parameter logic [31:0] OWN_RESET = `PLC_RST_OWN_A
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] pin_in,
    output plc_pkg::plc_drive_t pin_drive,
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    output logic [31:0] periph_in,
    output logic [31:0] line_owned
);
    import plc_pkg::*;

    logic [31:0] own_q, oe_q, gf_q, ol_q;
    logic [31:0] sync1_q, sync2_q, filt_q;
    logic [`PLC_GF_LEN-1:0] gf_cnt_q [32];
    logic aw_q, w_q, bvalid_q, rvalid_q;
    plc_wr_t wr_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Byte-lane mask from the strobes; partial writes touch only their lanes.
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Write channel decode; a write fires when both halves are held and no response is pending.
    wire wr_fire = aw_q && w_q && !bvalid_q;
    wire [31:0] wd = wr_q.data;
    wire hit_claim = wr_fire && wr_q.addr == `PLC_OFF_CLAIM;
    wire hit_rel = wr_fire && wr_q.addr == `PLC_OFF_RELEASE;
    wire hit_oes = wr_fire && wr_q.addr == `PLC_OFF_OE_SET;
    wire hit_oec = wr_fire && wr_q.addr == `PLC_OFF_OE_CLR;
    wire hit_gfs = wr_fire && wr_q.addr == `PLC_OFF_GF_SET;
    wire hit_gfc = wr_fire && wr_q.addr == `PLC_OFF_GF_CLR;
    wire hit_ols = wr_fire && wr_q.addr == `PLC_OFF_OL_SET;
    wire hit_olc = wr_fire && wr_q.addr == `PLC_OFF_OL_CLR;
    wire wr_ok = hit_claim | hit_rel | hit_oes | hit_oec | hit_gfs | hit_gfc |
                 hit_ols | hit_olc;

    // Ready only while the half is empty, so each side is taken once.
    assign s_axi_awready = clk_en && !aw_q;
    assign s_axi_wready = clk_en && !w_q;
    assign s_axi_arready = clk_en && !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Capture of address and data halves, in either order.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            wr_q <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                wr_q.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wr_q.data <= s_axi_wdata & lane_mask(s_axi_wstrb);
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `PLC_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `PLC_RESP_OKAY : `PLC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Configuration state: set and clear strobes work on stored bits only.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            own_q <= OWN_RESET;
            oe_q <= `PLC_RST_ZERO;
            gf_q <= `PLC_RST_ZERO;
            ol_q <= `PLC_RST_ZERO;
        end else if (clk_en) begin
            if (hit_claim) own_q <= own_q | wd;
            if (hit_rel) own_q <= own_q & ~wd;
            if (hit_oes) oe_q <= oe_q | wd;
            if (hit_oec) oe_q <= oe_q & ~wd;
            if (hit_gfs) gf_q <= gf_q | wd;
            if (hit_gfc) gf_q <= gf_q & ~wd;
            if (hit_ols) ol_q <= ol_q | wd;
            if (hit_olc) ol_q <= ol_q & ~wd;
        end
    end

    // Two-stage pin synchroniser; only the second stage feeds logic.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // Glitch filter: a new level must persist for the counter span.
    // With the clock frozen the filtered level simply holds.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            filt_q <= '0;
            for (int i = 0; i < 32; i++) gf_cnt_q[i] <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < 32; i++) begin
                if (sync2_q[i] == filt_q[i]) begin
                    gf_cnt_q[i] <= '0;
                end else if (&gf_cnt_q[i]) begin
                    filt_q[i] <= sync2_q[i];
                    gf_cnt_q[i] <= '0;
                end else begin
                    gf_cnt_q[i] <= gf_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // Input seen by both paths: filtered where selected, else synchronised.
    wire [31:0] in_level = (gf_q & filt_q) | (~gf_q & sync2_q);

    // Pin drive mux: controller bits act only on owned lines.
    assign pin_drive.line_out = (own_q & ol_q) | (~own_q & periph_out);
    assign pin_drive.line_oe = (own_q & oe_q) | (~own_q & periph_oe);
    assign periph_in = ~own_q & in_level;
    assign line_owned = own_q;

    // Read decode; strobe registers read as zero with no side effect.
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `PLC_OFF_OWN_STAT: rd_mux = own_q;
            `PLC_OFF_OE_STAT: rd_mux = oe_q;
            `PLC_OFF_GF_STAT: rd_mux = gf_q;
            `PLC_OFF_OL_STAT: rd_mux = ol_q;
            `PLC_OFF_PIN_STAT: rd_mux = in_level;
            `PLC_OFF_CLAIM, `PLC_OFF_RELEASE, `PLC_OFF_OE_SET,
            `PLC_OFF_OE_CLR, `PLC_OFF_GF_SET, `PLC_OFF_GF_CLR,
            `PLC_OFF_OL_SET, `PLC_OFF_OL_CLR: rd_mux = '0;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read response register.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `PLC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? `PLC_RESP_OKAY : `PLC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    property p_release;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_rel) |=> ((own_q & $past(wd)) == 32'h0);
    endproperty
    a_release: assert property (p_release) else $error("release kept");

    property p_claim;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_claim) |=> ((own_q & $past(wd)) == $past(wd));
    endproperty
    a_claim: assert property (p_claim) else $error("claim lost");

    property p_own_stable;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && !hit_claim && !hit_rel) |=> $stable(own_q);
    endproperty
    a_own_stable: assert property (p_own_stable)
        else $error("ownership moved");

    property p_oe_clear;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_oec) |=> ((oe_q & $past(wd)) == 32'h0);
    endproperty
    a_oe_clear: assert property (p_oe_clear) else $error("oe kept");

    property p_oe_set;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_oes) |=> ((oe_q & $past(wd)) == $past(wd));
    endproperty
    a_oe_set: assert property (p_oe_set) else $error("oe not set");

    property p_gf;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_gfs) |=> ((gf_q & $past(wd)) == $past(wd));
    endproperty
    a_gf: assert property (p_gf) else $error("filter not set");

    property p_gf_clr;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_gfc) |=> ((gf_q & $past(wd)) == 32'h0);
    endproperty
    a_gf_clr: assert property (p_gf_clr) else $error("filter kept");

    property p_hold;
        @(posedge mclk) disable iff (!nrst)
        !clk_en |=> $stable(filt_q) && $stable(sync2_q);
    endproperty
    a_hold: assert property (p_hold) else $error("held value moved");

    property p_latch;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_ols) |=> ((ol_q & $past(wd)) == $past(wd));
    endproperty
    a_latch: assert property (p_latch) else $error("latch not set");

    property p_latch_clr;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && hit_olc) |=> ((ol_q & $past(wd)) == 32'h0);
    endproperty
    a_latch_clr: assert property (p_latch_clr)
        else $error("latch kept");

    property p_pin_owned;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |-> ((pin_drive.line_oe & own_q) == (oe_q & own_q)) &&
                 ((periph_in & own_q) == 32'h0);
    endproperty
    a_pin_owned: assert property (p_pin_owned)
        else $error("owned drive wrong");

    // Every strobe offset has bit 3 clear and every status offset has it
    // set, so one address bit tells a strobe read from a status read.
    wire rd_strobe = rd_ok && !s_axi_araddr[3];

    // Strobe and ownership reads, refused writes, the frozen clock and the pad drive.
    property p_strobe_read;
        @(posedge mclk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready && rd_strobe) |=>
            (s_axi_rdata == 32'h0);
    endproperty
    a_strobe_read: assert property (p_strobe_read)
        else $error("strobe read not zero");

    property p_own_read;
        @(posedge mclk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready &&
            s_axi_araddr == `PLC_OFF_OWN_STAT) |=>
            (s_axi_rdata == $past(own_q));
    endproperty
    a_own_read: assert property (p_own_read)
        else $error("ownership read wrong");

    property p_bad_write;
        @(posedge mclk) disable iff (!nrst)
        (clk_en && wr_fire && !wr_ok) |=> $stable(own_q) && $stable(oe_q) &&
            $stable(gf_q) && $stable(ol_q);
    endproperty
    a_bad_write: assert property (p_bad_write)
        else $error("refused write changed state");

    property p_freeze;
        @(posedge mclk) disable iff (!nrst)
        !clk_en |=> $stable(own_q) && $stable(oe_q) && $stable(gf_q) &&
            $stable(ol_q) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");

    property p_periph_drive;
        @(posedge mclk) disable iff (!nrst)
        (((pin_drive.line_oe ^ periph_oe) & ~own_q) == 32'h0) &&
            (((pin_drive.line_out ^ periph_out) & ~own_q) == 32'h0);
    endproperty
    a_periph_drive: assert property (p_periph_drive)
        else $error("peripheral drive lost");

    property p_latch_pin;
        @(posedge mclk) disable iff (!nrst)
        (((pin_drive.line_out ^ ol_q) & own_q) == 32'h0);
    endproperty
    a_latch_pin: assert property (p_latch_pin)
        else $error("latch not on owned pin");

    c_write: cover property (@(posedge mclk) disable iff (!nrst)
        wr_fire ##[1:4] s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge mclk) disable iff (!nrst)
        s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
    c_filter: cover property (@(posedge mclk) disable iff (!nrst)
        (gf_q != 32'h0) && $changed(filt_q));
    c_partial: cover property (@(posedge mclk) disable iff (!nrst)
        s_axi_wvalid && s_axi_wready && s_axi_wstrb != 4'hf);
    c_freeze: cover property (@(posedge mclk) disable iff (!nrst)
        !clk_en && gf_q != 32'h0);
endmodule // plc_ctrl

/* src/plc_pkg.sv */
// Types shared by the line controller and its bench.
// Assumes the constants header is on the include path.
`include "plc_consts.svh"
package plc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
    } plc_wr_t;
    typedef struct packed {
        logic [31:0] line_out;
        logic [31:0] line_oe;
    } plc_drive_t;
endpackage

/* tb/plc_periph_model.sv */
// Peripheral and pad model that faces the line controller's pin side.
// Assumes the bench supplies the outside level of any pad left undriven.
`timescale 1ns/1ps
module plc_periph_model #(
    parameter logic [31:0] P_OE = 32'h000000f0,
    parameter logic [31:0] P_OUT = 32'h000000a0
) (
    input plc_pkg::plc_drive_t drive,
    input wire logic [31:0] ext,
    output logic [31:0] pin_in,
    output logic [31:0] periph_out,
    output logic [31:0] periph_oe
);
    import plc_pkg::*;
    // The peripheral drives a fixed set of lines with a fixed pattern.
    assign periph_oe = P_OE;
    assign periph_out = P_OUT;
    // A pad follows its driver; an undriven pad shows the outside level.
    assign pin_in = (drive.line_oe & drive.line_out) | (~drive.line_oe & ext);
endmodule // plc_periph_model

/* tb/tb.sv */
// Self-checking bench for the line controller, driven over AXI4-Lite.
// Assumes the controller and the peripheral model are compiled alongside.
`timescale 1ns/1ps
`include "plc_consts.svh"
module tb;
    import plc_pkg::*;
    localparam logic [31:0] P_OE = 32'h000000f0;
    localparam logic [31:0] P_OUT = 32'h000000a0;
    logic mclk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, pin_in;
    logic [31:0] ext = 32'h12345678;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] periph_out, periph_oe, periph_in, line_owned;
    plc_drive_t pin_drive;
    logic [31:0] own = `PLC_RST_OWN_A, oe = '0, lat = '0;
    logic [31:0] eoe, eout, pin;
    int n_fail = 0, comparisons = 0;

    // Expected pad drive and level, worked out from the tracked state.
    assign eoe = (own & oe) | (~own & P_OE);
    assign eout = (own & lat) | (~own & P_OUT);
    assign pin = (eoe & eout) | (~eoe & ext);

    // Free-running clock at 125 MHz.
    always #4 mclk = ~mclk;

    plc_ctrl dut (.mclk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_drive,
        .periph_out, .periph_oe, .periph_in, .line_owned);
    plc_periph_model #(.P_OE(P_OE), .P_OUT(P_OUT)) peri (.drive(pin_drive),
        .ext, .pin_in, .periph_out, .periph_oe);

    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Each half is released at the edge where it is taken, never earlier.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge mclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // The whole sequence needs well under a few thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end

    // Main sequence: reset values, every strobe register, errors, pins.
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rd(`PLC_OFF_OWN_STAT, `PLC_RST_OWN_A, `PLC_RESP_OKAY);
        rd(`PLC_OFF_OE_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        rd(`PLC_OFF_GF_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        rd(`PLC_OFF_OL_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        rd(`PLC_OFF_RELEASE, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        wr(`PLC_OFF_RELEASE, 32'h000002f3, `PLC_RESP_OKAY);
        own = own & ~32'h000002f3;
        rd(`PLC_OFF_OWN_STAT, own, `PLC_RESP_OKAY);
        chk(line_owned, own);
        wr(`PLC_OFF_CLAIM, 32'h00000001, `PLC_RESP_OKAY);
        own = own | 32'h00000001;
        rd(`PLC_OFF_OWN_STAT, own, `PLC_RESP_OKAY);
        wr(`PLC_OFF_OE_SET, 32'h000000ff, `PLC_RESP_OKAY);
        wr(`PLC_OFF_OE_CLR, 32'h0000000c, `PLC_RESP_OKAY);
        oe = 32'h000000f3;
        rd(`PLC_OFF_OE_STAT, oe, `PLC_RESP_OKAY);
        wr(`PLC_OFF_OL_SET, 32'h000000a5, `PLC_RESP_OKAY);
        wr(`PLC_OFF_OL_CLR, 32'h00000005, `PLC_RESP_OKAY);
        lat = 32'h000000a0;
        rd(`PLC_OFF_OL_STAT, lat, `PLC_RESP_OKAY);
        // Only the second byte lane is enabled, so only 0x0f00 lands.
        s_axi_wstrb <= 4'h2;
        wr(`PLC_OFF_OL_SET, 32'h00000f0f, `PLC_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        lat = 32'h00000fa0;
        rd(`PLC_OFF_OL_STAT, lat, `PLC_RESP_OKAY);
        wr(`PLC_OFF_GF_SET, 32'h00000300, `PLC_RESP_OKAY);
        wr(`PLC_OFF_GF_CLR, 32'h00000100, `PLC_RESP_OKAY);
        rd(`PLC_OFF_GF_STAT, 32'h00000200, `PLC_RESP_OKAY);
        wr(`PLC_OFF_OWN_STAT, 32'hffffffff, `PLC_RESP_SLVERR);
        rd(`PLC_OFF_OWN_STAT, own, `PLC_RESP_OKAY);
        rd(8'h40, `PLC_RST_ZERO, `PLC_RESP_SLVERR);
        // Let synchroniser and filter settle before judging the pads.
        repeat (20) @(posedge mclk);
        chk(pin_drive.line_oe, eoe);
        chk(pin_drive.line_out & eoe, eout & eoe);
        chk(periph_in, ~own & pin);
        rd(`PLC_OFF_PIN_STAT, pin, `PLC_RESP_OKAY);
        // With the clock stopped, a filtered input must not follow the pad.
        clk_en <= 1'b0;
        ext <= ext ^ 32'h00000200;
        repeat (20) @(posedge mclk);
        chk({31'h0, periph_in[9]}, {31'h0, ~ext[9]});
        clk_en <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(periph_in, ~own & pin);
        rd(`PLC_OFF_PIN_STAT, pin, `PLC_RESP_OKAY);
        // A second reset in mid-run must bring back every reset value.
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(`PLC_OFF_OWN_STAT, `PLC_RST_OWN_A, `PLC_RESP_OKAY);
        rd(`PLC_OFF_OE_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        rd(`PLC_OFF_GF_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        rd(`PLC_OFF_OL_STAT, `PLC_RST_ZERO, `PLC_RESP_OKAY);
        tally_and_finish();
    end
endmodule // tb
